// file: hdl/bus_switch.sv
/*
  Four-channel bus switch control: serial target engine on the link
  clock, which oversamples the upstream clock and data pins, and the
  channel enables on mclk_i that steer the external pass gates.
  Assumes link_clk_i runs free and far faster than the upstream clock,
  and that the pass gates themselves are outside this logic.
*/
`timescale 1ns/1ps
module bus_switch (
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  // Upstream serial pins
  input wire logic upstream_clock_i,
  input wire logic upstream_data_i,
  output logic upstream_data_o,
  output logic upstream_data_oe_n_o,
  // Hardware address pins
  input wire logic hw_addr_bit_zero_i,
  input wire logic hw_addr_bit_one_i,
  input wire logic hw_addr_bit_two_i,
  // Pass gate enables
  output logic chan_zero_enable_o,
  output logic chan_one_enable_o,
  output logic chan_two_enable_o,
  output logic chan_three_enable_o
);

  localparam int PIN_W = bus_switch_pkg::ADDR_HW_W + 2;
  localparam logic [PIN_W-1:0] PIN_IDLE = '1;

  // ---------------- Link domain ----------------
  logic link_rst_b;
  logic [PIN_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [bus_switch_pkg::ADDR_HW_W-1:0] hw_addr_s;

  // Release of reset lined up to the link clock
  sync2 #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_link_rst (
    .clk_i(link_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(1'b1),
    .q_o(link_rst_b)
  );

  // Pins idle high so reset never fakes a START
  sync2 #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_IDLE)
  ) u_pin_sync (
    .clk_i(link_clk_i),
    .rst_b_i(link_rst_b),
    .d_i({upstream_clock_i, upstream_data_i, hw_addr_bit_two_i,
          hw_addr_bit_one_i, hw_addr_bit_zero_i}),
    .q_o(pins_s)
  );

  assign scl_s = pins_s[PIN_W-1];
  assign sda_s = pins_s[PIN_W-2];
  assign hw_addr_s = pins_s[bus_switch_pkg::ADDR_HW_W-1:0];

  bus_switch_pkg::serial_state_t state_r, state_nxt;
  logic scl_d_r, scl_d_nxt;
  logic sda_d_r, sda_d_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [bus_switch_pkg::BYTE_W-1:0] shift_r, shift_nxt;
  logic [bus_switch_pkg::BYTE_W-1:0] channel_select_r;
  logic [bus_switch_pkg::BYTE_W-1:0] channel_select_nxt;
  logic [bus_switch_pkg::CHAN_NUM-1:0] active_sel_r, active_sel_nxt;
  logic pending_r, pending_nxt;
  logic commit_tgl_r, commit_tgl_nxt;
  logic drive_r, drive_nxt;
  logic rw_r, rw_nxt;
  logic master_ack_r, master_ack_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;
  logic [bus_switch_pkg::BYTE_W-1:0] rx_byte;

  // Data moves only while clock is low; a change while high is a condition
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign rx_byte = {shift_r[bus_switch_pkg::BYTE_W-2:0], sda_s};
  assign addr_match = (shift_r[bus_switch_pkg::ADDR_W-1:0] ==
                       {bus_switch_pkg::ADDR_FIXED, hw_addr_s});

  always_comb begin
    state_nxt = state_r;
    scl_d_nxt = scl_s;
    sda_d_nxt = sda_s;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    channel_select_nxt = channel_select_r;
    active_sel_nxt = active_sel_r;
    pending_nxt = pending_r;
    commit_tgl_nxt = commit_tgl_r;
    drive_nxt = drive_r;
    rw_nxt = rw_r;
    master_ack_nxt = master_ack_r;
    if (stop_cond) begin
      state_nxt = bus_switch_pkg::ST_IDLE;
      drive_nxt = 1'b0;
      if (pending_r) begin
        // Lines are all high now, safe to connect
        active_sel_nxt =
          channel_select_r[bus_switch_pkg::CHAN_NUM-1:0];
        commit_tgl_nxt = ~commit_tgl_r;
        pending_nxt = 1'b0;
      end
    end else if (start_cond) begin
      state_nxt = bus_switch_pkg::ST_ADDR;
      bit_cnt_nxt = bus_switch_pkg::BIT_FIRST;
      drive_nxt = 1'b0;
    end else begin
      unique case (state_r)
        bus_switch_pkg::ST_IDLE: begin
        end
        bus_switch_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shift_nxt = rx_byte;
            bit_cnt_nxt = bit_cnt_r + bus_switch_pkg::BIT_STEP;
            if (bit_cnt_r == bus_switch_pkg::BIT_LAST) begin
              rw_nxt = sda_s;
              if (addr_match) begin
                state_nxt = bus_switch_pkg::ST_ADDR_ACK;
              end else begin
                state_nxt = bus_switch_pkg::ST_IDLE;
              end
            end
          end
        end
        bus_switch_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (!drive_r) begin
              drive_nxt = 1'b1;
            end else if (rw_r) begin
              shift_nxt = channel_select_r;
              drive_nxt = ~channel_select_r[bus_switch_pkg::BYTE_W-1];
              bit_cnt_nxt = bus_switch_pkg::BIT_FIRST;
              state_nxt = bus_switch_pkg::ST_RD_DATA;
            end else begin
              drive_nxt = 1'b0;
              bit_cnt_nxt = bus_switch_pkg::BIT_FIRST;
              state_nxt = bus_switch_pkg::ST_WR_DATA;
            end
          end
        end
        bus_switch_pkg::ST_WR_DATA: begin
          if (scl_rise) begin
            shift_nxt = rx_byte;
            bit_cnt_nxt = bit_cnt_r + bus_switch_pkg::BIT_STEP;
            if (bit_cnt_r == bus_switch_pkg::BIT_LAST) begin
              channel_select_nxt = rx_byte;
              pending_nxt = 1'b1;
              state_nxt = bus_switch_pkg::ST_WR_ACK;
            end
          end
        end
        bus_switch_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            if (!drive_r) begin
              drive_nxt = 1'b1;
            end else begin
              drive_nxt = 1'b0;
              bit_cnt_nxt = bus_switch_pkg::BIT_FIRST;
              state_nxt = bus_switch_pkg::ST_WR_DATA;
            end
          end
        end
        bus_switch_pkg::ST_RD_DATA: begin
          if (scl_fall) begin
            shift_nxt = {shift_r[bus_switch_pkg::BYTE_W-2:0], 1'b0};
            drive_nxt = ~shift_r[bus_switch_pkg::BYTE_W-2];
          end
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + bus_switch_pkg::BIT_STEP;
            if (bit_cnt_r == bus_switch_pkg::BIT_LAST) begin
              state_nxt = bus_switch_pkg::ST_RD_ACK;
            end
          end
        end
        bus_switch_pkg::ST_RD_ACK: begin
          // Count wrapped to zero: first fall releases, rise samples
          if (scl_rise) begin
            master_ack_nxt = ~sda_s;
            bit_cnt_nxt = bus_switch_pkg::BIT_STEP;
          end
          if (scl_fall) begin
            if (bit_cnt_r == bus_switch_pkg::BIT_FIRST) begin
              drive_nxt = 1'b0;
            end else if (master_ack_r) begin
              shift_nxt = channel_select_r;
              drive_nxt = ~channel_select_r[bus_switch_pkg::BYTE_W-1];
              bit_cnt_nxt = bus_switch_pkg::BIT_FIRST;
              state_nxt = bus_switch_pkg::ST_RD_DATA;
            end else begin
              drive_nxt = 1'b0;
              state_nxt = bus_switch_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      state_r <= bus_switch_pkg::ST_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_cnt_r <= bus_switch_pkg::BIT_FIRST;
      shift_r <= bus_switch_pkg::CTRL_RESET;
      channel_select_r <= bus_switch_pkg::CTRL_RESET;
      active_sel_r <= bus_switch_pkg::SEL_RESET;
      pending_r <= 1'b0;
      commit_tgl_r <= 1'b0;
      drive_r <= 1'b0;
      rw_r <= 1'b0;
      master_ack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      channel_select_r <= channel_select_nxt;
      active_sel_r <= active_sel_nxt;
      pending_r <= pending_nxt;
      commit_tgl_r <= commit_tgl_nxt;
      drive_r <= drive_nxt;
      rw_r <= rw_nxt;
      master_ack_r <= master_ack_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign upstream_data_o = 1'b0;
  assign upstream_data_oe_n_o = ~drive_r;

  // ---------------- mclk domain ----------------
  logic sys_rst_b;
  logic tgl_s;
  logic tgl_d_r, tgl_d_nxt;
  logic [bus_switch_pkg::CHAN_NUM-1:0] conn_r, conn_nxt;

  sync2 #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_sys_rst (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .d_i(1'b1),
    .q_o(sys_rst_b)
  );

  sync2 #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_tgl_sync (
    .clk_i(mclk_i),
    .rst_b_i(sys_rst_b),
    .d_i(commit_tgl_r),
    .q_o(tgl_s)
  );

  // Selection word is held still from the toggle until the next STOP
  always_comb begin
    tgl_d_nxt = tgl_s;
    conn_nxt = conn_r;
    if (tgl_s != tgl_d_r) begin
      conn_nxt = active_sel_r;
    end
  end

  always_ff @(posedge mclk_i or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      tgl_d_r <= 1'b0;
      conn_r <= bus_switch_pkg::SEL_RESET;
    end else begin
      tgl_d_r <= tgl_d_nxt;
      conn_r <= conn_nxt;
    end
  end

  assign chan_zero_enable_o = conn_r[0];
  assign chan_one_enable_o = conn_r[1];
  assign chan_two_enable_o = conn_r[2];
  assign chan_three_enable_o = conn_r[3];

endmodule

// file: hdl/sync2.sv
/*
  Two-flop synchroniser of parameter width with asynchronous reset to a
  parameter constant. Assumes each bit is an independent level.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule

// file: inc/bus_switch_pkg.sv
/*
  Shared constants and the serial state type for the four-channel bus
  switch. Assumes it is compiled ahead of every file under hdl/.
*/
// How it works
// - Upstream pair connects to any one channel or any mix of channels.
// - Reset input low idles the serial engine and disconnects all channels.
// - After power-on reset no channel is connected.
// - Three address pins form part of the target address; eight per bus.
// - Last address bit one means read, zero means write.
// - After address acknowledge, the next written byte loads the register.
// - With several written bytes only the last one is kept.
// - Register is writable and readable; a read returns the selection.
// - Bit n of the low nibble enables channel n, zero disables it.
// - A new selection only connects after a STOP on the upstream bus.
// - Upstream clock may run from standstill up to 400 kHz.
// - Address and every received byte acknowledged by pulling data low.
package bus_switch_pkg;

  localparam int BYTE_W = 8;
  localparam int CHAN_NUM = 4;
  localparam int ADDR_HW_W = 3;
  localparam int ADDR_W = 7;
  localparam int SCL_MAX_KHZ = 400;

  // Upper nibble of the target address; the pins fill the rest
  localparam logic [3:0] ADDR_FIXED = 4'hE;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR_DATA  = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD_DATA  = 7'h20,
    ST_RD_ACK   = 7'h40
  } serial_state_t;

endpackage

// file: testbench/bus_master.sv
/* Upstream bus master model, about 390 kHz SCL.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
module bus_master (
  // Clock
  input wire logic mclk_i,
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q();
    repeat (16) @(negedge mclk_i);
  endtask
  task automatic start();
    sda_o = 1'b0;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b1;
    q();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    sda_o = b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      clk_bit(tx[i], rx[i]);
    clk_bit(mack, ack);
  endtask
endmodule

// file: testbench/bus_switch_properties.sv
/* Checker on the bus switch top ports.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
module bus_switch_properties (
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  // Upstream pins
  input wire logic upstream_clock_i,
  input wire logic upstream_data_i,
  input wire logic upstream_data_o,
  input wire logic upstream_data_oe_n_o,
  // Enables
  input wire logic chan_zero_enable_o,
  input wire logic chan_one_enable_o,
  input wire logic chan_two_enable_o,
  input wire logic chan_three_enable_o
);
  logic [3:0] chans;
  logic [7:0] stop_cnt;
  logic m_scl_q, m_sda_q, l_scl_q, l_sda_q, busy, l_start, l_stop, m_stop;
  assign chans = {chan_three_enable_o, chan_two_enable_o,
                  chan_one_enable_o, chan_zero_enable_o};
  assign l_start = l_scl_q & upstream_clock_i & l_sda_q & ~upstream_data_i;
  assign l_stop = l_scl_q & upstream_clock_i & ~l_sda_q & upstream_data_i;
  assign m_stop = m_scl_q & upstream_clock_i & ~m_sda_q & upstream_data_i;
  // Cycles since the last STOP, saturating
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      m_scl_q <= 1'b1;
      m_sda_q <= 1'b1;
      stop_cnt <= 8'hFF;
    end else begin
      m_scl_q <= upstream_clock_i;
      m_sda_q <= upstream_data_i;
      stop_cnt <= m_stop ? 8'h00 : stop_cnt + {7'h0, stop_cnt != 8'hFF};
    end
  end
  // Bus busy between START and STOP
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      l_scl_q <= 1'b1;
      l_sda_q <= 1'b1;
      busy <= 1'b0;
    end else begin
      l_scl_q <= upstream_clock_i;
      l_sda_q <= upstream_data_i;
      busy <= l_start | (busy & ~l_stop);
    end
  end
  a_data_zero: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i) !upstream_data_o)
    else $error("Data output not held low");
  a_chan_rst_clear: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> (chans == 4'h0) [*2])
    else $error("Channel enabled out of reset");
  a_oe_rst_free: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> upstream_data_oe_n_o [*2])
    else $error("Data driven out of reset");
  a_chan_after_stop: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    !$stable(chans) |-> stop_cnt <= 8'h08)
    else $error("Channels changed without a STOP");
  a_sda_scl_low: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i)
    $changed(upstream_data_oe_n_o) |-> !upstream_clock_i)
    else $error("Data drive changed while clock high");
  a_ack_hold: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i)
    $rose(upstream_clock_i) && !upstream_data_oe_n_o
      |-> !upstream_data_oe_n_o [*8])
    else $error("Data drive dropped in clock high");
  a_idle_no_drive: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i)
    !busy |-> upstream_data_oe_n_o)
    else $error("Data driven on idle bus");
  a_start_quiet: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i)
    l_start |-> upstream_data_oe_n_o [*8])
    else $error("Data driven right after START");
endmodule

// file: testbench/test_bus_switch.sv
/* Bench for the bus switch: register written and read over the
   upstream bus through the master model. */
`timescale 1ns/1ps
module test_bus_switch;
  logic mclk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] pins = 3'h0;
  logic scl, m_sda, sda, d_o, oe_n, ack;
  logic [3:0] chans;
  logic [7:0] rx;
  int failures = 0;
  int cmp_count = 0;
  always #20 mclk_i = ~mclk_i;
  initial begin
    #3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  assign sda = m_sda & (oe_n | d_o);
  bus_switch i_bus_switch (
    .mclk_i(mclk_i), .link_clk_i(link_clk_i), .rst_b_i(rst_b_i),
    .upstream_clock_i(scl), .upstream_data_i(sda),
    .upstream_data_o(d_o), .upstream_data_oe_n_o(oe_n),
    .hw_addr_bit_zero_i(pins[0]), .hw_addr_bit_one_i(pins[1]),
    .hw_addr_bit_two_i(pins[2]),
    .chan_zero_enable_o(chans[0]), .chan_one_enable_o(chans[1]),
    .chan_two_enable_o(chans[2]), .chan_three_enable_o(chans[3]));
  bus_master i_bus_master (
    .mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [3:0] e);
    repeat (4) @(negedge mclk_i);
    check({4'h0, chans}, {4'h0, e});
  endtask
  // Write n bytes of d, high byte first; hold leaves the STOP out
  task automatic wr(input logic [6:0] a, input logic [15:0] d,
                    input int n, input logic nak, input logic hold);
    i_bus_master.start();
    i_bus_master.xfer({a, 1'b0}, 1'b1, rx, ack);
    check({7'h0, ack}, {7'h0, nak});
    for (int i = n - 1; i >= 0; i--) begin
      i_bus_master.xfer(d[i*8 +: 8], 1'b1, rx, ack);
      check({7'h0, ack}, {7'h0, nak});
    end
    if (!hold)
      i_bus_master.stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    i_bus_master.start();
    i_bus_master.xfer({a, 1'b1}, 1'b1, rx, ack);
    check({7'h0, ack}, 8'h00);
    // Master acks the first byte, so the register comes again
    i_bus_master.xfer(8'hFF, 1'b0, rx, ack);
    check(rx, exp);
    i_bus_master.xfer(8'hFF, 1'b1, rx, ack);
    check(rx, exp);
    i_bus_master.stop();
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_b_i = 1'b1;
    chk(4'h0);
    wr(7'h70, 16'h00A5, 1, 1'b0, 1'b1);
    chk(4'h0);
    i_bus_master.stop();
    chk(4'h5);
    rd(7'h70, 8'hA5);
    wr(7'h70, 16'h030C, 2, 1'b0, 1'b0);
    chk(4'hC);
    rd(7'h70, 8'h0C);
    wr(7'h71, 16'h0003, 1, 1'b1, 1'b0);
    wr(7'h30, 16'h0003, 1, 1'b1, 1'b0);
    chk(4'hC);
    for (int p = 0; p < 8; p++) begin
      pins = p[2:0];
      wr({bus_switch_pkg::ADDR_FIXED, p[2:0]}, {13'h0, p[2:0]}, 1,
         1'b0, 1'b0);
      chk(p[3:0]);
    end
    i_bus_master.start();
    i_bus_master.xfer(8'hEE, 1'b1, rx, ack);
    rst_b_i = 1'b0;
    chk(4'h0);
    i_bus_master.stop();
    rst_b_i = 1'b1;
    chk(4'h0);
    rd(7'h77, 8'h00);
    wrap_up();
  end
  initial begin
    #2000000;
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
bind bus_switch bus_switch_properties i_bus_switch_properties (
  .mclk_i(mclk_i), .link_clk_i(link_clk_i), .rst_b_i(rst_b_i),
  .upstream_clock_i(upstream_clock_i), .upstream_data_i(upstream_data_i),
  .upstream_data_o(upstream_data_o),
  .upstream_data_oe_n_o(upstream_data_oe_n_o),
  .chan_zero_enable_o(chan_zero_enable_o),
  .chan_one_enable_o(chan_one_enable_o),
  .chan_two_enable_o(chan_two_enable_o),
  .chan_three_enable_o(chan_three_enable_o));
